//--- src/ivr_pkg.sv
// constants, register layout and state codes of the voltage-code bank
// assumes a 40 MHz system clock; shared by the filter and the core
package ivr_pkg;

   // register offsets, taken from the pointer byte of a write
   localparam logic [7:0] IVR_OFS_VOLTAGE_CODE     = 8'h00;
   localparam logic [7:0] IVR_OFS_CFG      = 8'h01;

   // voltage register: code in [6:0], parity guard in bit 7
   localparam int         IVR_PAR_BIT      = 7;
   localparam logic [6:0] IVR_CODE_RST     = 7'h32;
   localparam logic [7:0] IVR_VOLTAGE_CODE_RST     = {~^IVR_CODE_RST, IVR_CODE_RST};

   // configuration register fields
   localparam int         IVR_CFG_INT_BIT  = 7;
   localparam int         IVR_CFG_MASK_BIT = 4;
   localparam int         IVR_CFG_LL_BIT   = 3;
   localparam int         IVR_CFG_PROT_BIT = 0;
   localparam logic [7:0] IVR_CFG_RST      = 8'h09;
   localparam logic [7:0] IVR_CFG_WR_MASK  = 8'h99;

   // target address, plain default
   localparam logic [6:0] IVR_ADDR_DEF     = 7'h2a;

   // timing
   localparam int         IVR_CLK_NS       = 25;
   localparam int         IVR_SPIKE_NS     = 32;
   localparam int         IVR_SPIKE_CYC    =
      (IVR_SPIKE_NS + IVR_CLK_NS - 1) / IVR_CLK_NS;
   localparam logic [1:0] IVR_FILT_CNT     = 2'(IVR_SPIKE_CYC + 1);
   localparam int         IVR_SLEW_US      = 15;
   localparam logic [9:0] IVR_SLEW_CYC     =
      10'(IVR_SLEW_US * 1000 / IVR_CLK_NS);

   // serial engine states
   typedef enum logic [2:0]
   {
      IVR_ST_IDLE = 3'b000,
      IVR_ST_ADDR = 3'b001,
      IVR_ST_WPTR = 3'b010,
      IVR_ST_WDAT = 3'b011,
      IVR_ST_RDAT = 3'b100,
      IVR_ST_IGN  = 3'b101
   } ivr_state_t;

endpackage

//--- src/ivr_line_if.sv
// filtered bus lines and their events, from filter to core
// assumes both ends share clk_sys_i
`timescale 1ns/1ps
interface ivr_line_if;
   logic scl;
   logic sda;
   logic start;
   logic stop;
   logic scl_rise;
   logic scl_fall;

   modport filt (output scl, sda, start, stop, scl_rise, scl_fall);
   modport core (input  scl, sda, start, stop, scl_rise, scl_fall);
endinterface

//--- src/ivr_line_filt.sv
// spike filter on both bus lines plus start, stop and clock edge events
// assumes scl_i and sda_i already synchronous to clk_sys_i
`timescale 1ns/1ps
module ivr_line_filt
   import ivr_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys_i,
   input  wire logic rst_b_i,
   // raw bus lines
   input  wire logic scl_i,
   input  wire logic sda_i,
   // filtered lines and events
   ivr_line_if.filt  bus
);
   logic [1:0] raw;
   logic [1:0] lvl_r;
   logic [1:0] prev_r;

   assign raw = {scl_i, sda_i};

   // one filter per line; a level is taken only after it held long
   // enough that no suppressed spike can reach it
   for (genvar g = 0; g < 2; g++)
   begin : g_line
      logic [1:0] cnt_r;
      always_ff @(posedge clk_sys_i or negedge rst_b_i)
      begin
         if (!rst_b_i)
         begin
            lvl_r[g] <= 1'b1;
            cnt_r    <= 2'h0;
         end
         else if (raw[g] == lvl_r[g])
            cnt_r <= 2'h0;
         else if (cnt_r == IVR_FILT_CNT - 2'h1)
         begin
            lvl_r[g] <= raw[g];                  // see R13
            cnt_r    <= 2'h0;
         end
         else
            cnt_r <= cnt_r + 2'h1;
      end

      property p_spike;
         @(posedge clk_sys_i) disable iff (!rst_b_i)
         $changed(lvl_r[g]) |->
            $past(raw[g], 1) == lvl_r[g] && $past(raw[g], 2) == lvl_r[g]
            && $past(raw[g], 3) == lvl_r[g];
      endproperty
      a_spike: assert property (p_spike) // see R13
         else $error("filtered line moved on a short spike");
   end

   // events from filtered levels, all registered
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         prev_r       <= 2'h3;
         bus.start    <= 1'b0;
         bus.stop     <= 1'b0;
         bus.scl_rise <= 1'b0;
         bus.scl_fall <= 1'b0;
      end
      else
      begin
         prev_r       <= lvl_r;
         bus.start    <= prev_r[1] & lvl_r[1] & prev_r[0] & ~lvl_r[0];
         bus.stop     <= prev_r[1] & lvl_r[1] & ~prev_r[0] & lvl_r[0];
         bus.scl_rise <= ~prev_r[1] & lvl_r[1];
         bus.scl_fall <= prev_r[1] & ~lvl_r[1];
      end
   end

   assign bus.scl = prev_r[1];
   assign bus.sda = prev_r[0];

endmodule

//--- src/ivr_regs.sv
// serial target port with voltage-code and configuration registers
// assumes bus lines synchronous to clk_sys_i, open-drain wire outside,
// and power status inputs synchronous as well
`timescale 1ns/1ps
// Operation
// R1: voltage register holds code in bits 6..0, parity guard in bit 7.
// R2: after any default reset the code reads 0110010.
// R3: controller sets guard bit to the XNOR of the seven code bits.
// R4: wrong guard bit: no data acknowledge, stored contents unchanged.
// R5: voltage register reads back guard bit and code bits.
// R6: controller repeats a write that was not acknowledged.
// R7: control-source bit defaults 0; at 1 stored code governs output.
// R8: writing 0 to control-source bit returns to external control now.
// R9: mask bit defaults 0; at 1 protection is off during code change.
// R10: light-load bit: 0 pulse-frequency, 1 fixed pulse-width; default 1.
// R11: fault bit: 0 auto-recovery, 1 latch-off; default latch-off.
// R12: defaults restored on no power, supply lockout, or enable low.
// R13: glitches of 32 ns or less on bus inputs are ignored.
// R14: address compared after each start; acknowledge on ninth pulse.
// R15: address mismatch: ignore data, no acknowledge, await next start.
// R16: direction bit 0 is a write, 1 is a read.
// R17: read shifts out register bits, idles at stop regardless of ack.
// R18: undefined config bits read zero; other offsets change nothing.
module ivr_regs
   import ivr_pkg::*;
#(
   parameter logic [6:0] TGT_ADDR = ivr_pkg::IVR_ADDR_DEF
)
(
   // clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_b_i,
   // serial bus, data line as open drain
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   // power status
   input  wire logic       supply_present_i,
   input  wire logic       supply_lockout_i,
   input  wire logic       enable_i,
   // regulator controls
   output logic            internal_mode_o,
   output logic [6:0]      voltage_select_value_o,
   output logic            prot_suppress_o,
   output logic            light_load_select_o,
   output logic            latch_off_o
);
   import ivr_pkg::*;

   ivr_line_if  bus ();

   ivr_state_t  state_r;
   logic [3:0]  bit_cnt_r;
   logic        ack_ph_r;
   logic        mack_r;
   logic [7:0]  shift_r;
   logic [7:0]  ptr_r;
   logic [7:0]  voltage_code_r;
   logic [7:0]  cfg_r;
   logic [9:0]  slew_cnt_r;
   logic        soft_clr;
   logic        byte_done;
   logic        ack_end;
   logic        par_bad;
   logic        addr_hit;
   logic        wr_ok;
   logic        wr_bad;
   logic        code_chg;
   logic [7:0]  rd_byte;
   logic [2:0]  rd_idx;

   ivr_line_filt u_filt
   (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .bus       (bus.filt)
   );

   // defaults return while power is missing or the part is disabled
   assign soft_clr  = !supply_present_i || supply_lockout_i || !enable_i;

   // byte boundary and end of the acknowledge slot, on falling clock
   assign byte_done = bus.scl_fall && !ack_ph_r && bit_cnt_r == 4'h8;
   assign ack_end   = bus.scl_fall && ack_ph_r;

   // guard must be XNOR of the code bits
   assign par_bad   = shift_r[IVR_PAR_BIT] != ~^shift_r[6:0]; // see R3
   assign addr_hit  = shift_r[7:1] == TGT_ADDR;
   assign wr_bad    = byte_done && state_r == IVR_ST_WDAT
                      && ptr_r == IVR_OFS_VOLTAGE_CODE && par_bad;
   assign wr_ok     = byte_done && state_r == IVR_ST_WDAT && !wr_bad
                      && !soft_clr;
   assign code_chg  = wr_ok && ptr_r == IVR_OFS_VOLTAGE_CODE
                      && shift_r[6:0] != voltage_code_r[6:0];

   // readback source; unmapped offsets read zero
   always_comb
   begin
      rd_byte = 8'h00;
      case (ptr_r)
         IVR_OFS_VOLTAGE_CODE: rd_byte = voltage_code_r;                     // see R5
         IVR_OFS_CFG:  rd_byte = cfg_r;
         default:      rd_byte = 8'h00;                      // see R18
      endcase
   end
   assign rd_idx = 3'(4'h7 - bit_cnt_r);

   // serial engine and data line driver
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_r   <= IVR_ST_IDLE;
         bit_cnt_r <= 4'h0;
         ack_ph_r  <= 1'b0;
         mack_r    <= 1'b0;
         shift_r   <= 8'h00;
         ptr_r     <= 8'h00;
         sda_oe_o  <= 1'b0;
      end
      else if (soft_clr || bus.stop)
      begin
         state_r  <= IVR_ST_IDLE;                            // see R17
         ack_ph_r <= 1'b0;
         sda_oe_o <= 1'b0;
         if (soft_clr)
            ptr_r <= 8'h00;
      end
      else if (bus.start)
      begin
         state_r   <= IVR_ST_ADDR;                           // see R14
         bit_cnt_r <= 4'h0;
         ack_ph_r  <= 1'b0;
         sda_oe_o  <= 1'b0;
      end
      else if (state_r == IVR_ST_IDLE || state_r == IVR_ST_IGN)
         sda_oe_o <= 1'b0;                                   // see R15
      else if (bus.scl_rise)
      begin
         if (ack_ph_r)
            mack_r <= !bus.sda;
         else
         begin
            shift_r   <= {shift_r[6:0], bus.sda};
            bit_cnt_r <= bit_cnt_r + 4'h1;
         end
      end
      else if (byte_done)
      begin
         ack_ph_r <= 1'b1;
         case (state_r)
            IVR_ST_ADDR:
            begin
               if (addr_hit)
               begin
                  sda_oe_o <= 1'b1;                          // see R14
                  state_r  <= shift_r[0] ? IVR_ST_RDAT       // see R16
                                         : IVR_ST_WPTR;
               end
               else
               begin
                  sda_oe_o <= 1'b0;
                  state_r  <= IVR_ST_IGN;                    // see R15
               end
            end
            IVR_ST_WPTR:
            begin
               ptr_r    <= shift_r;
               sda_oe_o <= 1'b1;
               state_r  <= IVR_ST_WDAT;
            end
            IVR_ST_WDAT:
            begin
               sda_oe_o <= !wr_bad;                          // see R4
               if (wr_bad)
                  state_r <= IVR_ST_IGN;
            end
            IVR_ST_RDAT:
               sda_oe_o <= 1'b0;
            default:
               sda_oe_o <= 1'b0;
         endcase
      end
      else if (ack_end)
      begin
         ack_ph_r  <= 1'b0;
         bit_cnt_r <= 4'h0;
         // own address ack also reads as an ack here, so the first bit
         // goes out right after it
         if (state_r == IVR_ST_RDAT && mack_r)
            sda_oe_o <= !rd_byte[7];                         // see R17
         else if (state_r == IVR_ST_RDAT)
         begin
            sda_oe_o <= 1'b0;
            state_r  <= IVR_ST_IGN;
         end
         else
            sda_oe_o <= 1'b0;
      end
      else if (bus.scl_fall && state_r == IVR_ST_RDAT)
         sda_oe_o <= !rd_byte[rd_idx];                       // see R17
   end

   // register file; reserved config bits never store
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         voltage_code_r <= IVR_VOLTAGE_CODE_RST;                             // see R2
         cfg_r  <= IVR_CFG_RST;
      end
      else if (soft_clr)
      begin
         voltage_code_r <= IVR_VOLTAGE_CODE_RST;                             // see R12
         cfg_r  <= IVR_CFG_RST;                   // see R7, R9, R10, R11
      end
      else if (wr_ok && ptr_r == IVR_OFS_VOLTAGE_CODE)
         voltage_code_r <= shift_r;                                  // see R1
      else if (wr_ok && ptr_r == IVR_OFS_CFG)
         cfg_r  <= shift_r & IVR_CFG_WR_MASK;                // see R18
   end

   // window covering the worst-case output slew after a code change
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         slew_cnt_r <= 10'h000;
      else if (soft_clr)
         slew_cnt_r <= 10'h000;
      else if (code_chg)
         slew_cnt_r <= IVR_SLEW_CYC;
      else if (slew_cnt_r != 10'h000)
         slew_cnt_r <= slew_cnt_r - 10'h001;
   end

   // regulator controls, registered
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         internal_mode_o        <= 1'b0;
         voltage_select_value_o <= IVR_CODE_RST;
         prot_suppress_o        <= 1'b0;
         light_load_select_o    <= 1'b1;
         latch_off_o            <= 1'b1;
      end
      else
      begin
         internal_mode_o        <= cfg_r[IVR_CFG_INT_BIT];  // see R7, R8
         voltage_select_value_o <= voltage_code_r[6:0];
         prot_suppress_o        <= cfg_r[IVR_CFG_MASK_BIT]  // see R9
                                   && (code_chg || slew_cnt_r != 10'h000);
         light_load_select_o    <= cfg_r[IVR_CFG_LL_BIT];    // see R10
         latch_off_o            <= cfg_r[IVR_CFG_PROT_BIT];  // see R11
      end
   end

   // data line only ever pulls low
   assign sda_o = 1'b0;

   sequence s_bad_byte;
      wr_bad && !soft_clr && !bus.stop && !bus.start;
   endsequence

   property p_bad_nack;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      s_bad_byte |=> !sda_oe_o && $stable(voltage_code_r);
   endproperty
   a_bad_nack: assert property (p_bad_nack) // see R4
      else $error("bad guard bit was acknowledged or stored");

   property p_good_store;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_ok && ptr_r == IVR_OFS_VOLTAGE_CODE && !bus.stop)
         |=> sda_oe_o && voltage_code_r == $past(shift_r);
   endproperty
   a_good_store: assert property (p_good_store) // see R1
      else $error("valid voltage byte not stored or not acknowledged");

   property p_defaults;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      soft_clr |=> voltage_code_r == IVR_VOLTAGE_CODE_RST && cfg_r == IVR_CFG_RST
         ##1 voltage_select_value_o == IVR_CODE_RST && latch_off_o;
   endproperty
   a_defaults: assert property (p_defaults) // see R12
      else $error("defaults not restored after power loss or disable");

   property p_addr_ack;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (byte_done && state_r == IVR_ST_ADDR && addr_hit && !soft_clr
       && !bus.stop && !bus.start) |=> sda_oe_o;
   endproperty
   a_addr_ack: assert property (p_addr_ack) // see R14
      else $error("matched address not acknowledged");

   sequence s_miss;
      byte_done && state_r == IVR_ST_ADDR && !addr_hit && !soft_clr
      && !bus.stop && !bus.start;
   endsequence

   property p_addr_miss;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      s_miss |=> (!sda_oe_o && state_r == IVR_ST_IGN) [*2];
   endproperty
   a_addr_miss: assert property (p_addr_miss) // see R15
      else $error("foreign address drew a response");

   property p_reserved;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (cfg_r & ~IVR_CFG_WR_MASK) == 8'h00;
   endproperty
   a_reserved: assert property (p_reserved) // see R18
      else $error("reserved configuration bit became set");

   property p_ext_mode;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      $fell(cfg_r[IVR_CFG_INT_BIT]) |-> ##1 !internal_mode_o;
   endproperty
   a_ext_mode: assert property (p_ext_mode) // see R8
      else $error("external control not restored at once");

   property p_suppress;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (code_chg && cfg_r[IVR_CFG_MASK_BIT]) |=> prot_suppress_o [*8];
   endproperty
   a_suppress: assert property (p_suppress) // see R9
      else $error("protection not suppressed during code change");

   property p_no_mask;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      !cfg_r[IVR_CFG_MASK_BIT] |=> !prot_suppress_o;
   endproperty
   a_no_mask: assert property (p_no_mask) // see R9
      else $error("protection suppressed while mask bit clear");

   property p_read_bit;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (bus.scl_fall && state_r == IVR_ST_RDAT && !ack_ph_r
       && bit_cnt_r != 4'h0 && bit_cnt_r < 4'h8 && !bus.stop
       && !bus.start && !soft_clr)
         |=> sda_oe_o == !$past(rd_byte[rd_idx]);
   endproperty
   a_read_bit: assert property (p_read_bit) // see R17
      else $error("read bit driven wrong");

endmodule

//--- dv/ivr_host_bfm.sv
// bus controller model: start, stop, byte transfers and register access
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
module ivr_host_bfm
#(
   parameter int Q = 8
)
(
   // clock
   input  wire logic clk_sys_i,
   // resolved data wire
   input  wire logic sda_i,
   // driven lines, 1 means released
   output logic      scl_o,
   output logic      sda_o
);
   logic spike_en;

   // idle bus at time zero, spike injection off
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      spike_en = 1'b0;
   end

   // quarter bit periods, all changes on the falling clock edge
   task automatic hold(input int n);
      repeat (n * Q) @(negedge clk_sys_i);
   endtask

   task automatic start();
      sda_o = 1'b1;
      hold(1);
      scl_o = 1'b1;
      hold(1);
      sda_o = 1'b0;
      hold(1);
      scl_o = 1'b0;
   endtask

   // data moves only a quarter after the clock fall, never with it
   task automatic stop();
      hold(1);
      sda_o = 1'b0;
      hold(1);
      scl_o = 1'b1;
      hold(1);
      sda_o = 1'b1;
      hold(2);
   endtask

   // one bit; optional one-cycle spike while the clock is high
   task automatic bit_xfer(input logic b, output logic s);
      hold(1);
      sda_o = b;
      hold(1);
      scl_o = 1'b1;
      hold(1);
      if (spike_en)
      begin
         sda_o = ~b;
         @(negedge clk_sys_i);
         sda_o = b;
      end
      hold(1);
      s = sda_i;
      scl_o = 1'b0;
   endtask

   // msb first, then the acknowledge slot
   task automatic byte_xfer(input logic [7:0] d, input logic a_in,
                            output logic [7:0] r, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_xfer(d[i], s);
         r[i] = s;
      end
      bit_xfer(a_in, s);
      ack = ~s;
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] p,
                     input logic [7:0] d, output logic [2:0] k);
      logic [7:0] r;
      start();
      byte_xfer({a, 1'b0}, 1'b1, r, k[2]);
      byte_xfer(p, 1'b1, r, k[1]);
      byte_xfer(d, 1'b1, r, k[0]);
      stop();
   endtask

   // pointer set by a short write, then a one-byte read ended by nack
   task automatic rd(input logic [6:0] a, input logic [7:0] p,
                     output logic [7:0] d, output logic ack);
      logic [7:0] r;
      logic       k;
      start();
      byte_xfer({a, 1'b0}, 1'b1, r, k);
      byte_xfer(p, 1'b1, r, k);
      stop();
      start();
      byte_xfer({a, 1'b1}, 1'b1, r, ack);
      byte_xfer(8'hff, 1'b1, d, k);
      stop();
   endtask

   // read of two bytes: controller acks the first, nacks the second
   task automatic rd2(input logic [6:0] a, output logic [15:0] d);
      logic [7:0] r;
      logic       k;
      start();
      byte_xfer({a, 1'b1}, 1'b1, r, k);
      byte_xfer(8'hff, 1'b0, d[15:8], k);
      byte_xfer(8'hff, 1'b1, d[7:0], k);
      stop();
   endtask

   // code write with guard bit; a refused write is sent once more
   task automatic wr_code(input logic [6:0] a, input logic [6:0] c,
                          output logic [2:0] k);
      logic [2:0] k2;
      wr(a, 8'h00, {~^c, c}, k);
      if (k[0] !== 1'b1)
         wr(a, 8'h00, {~^c, c}, k2);
   endtask
endmodule

//--- dv/ivr_regs_tb.sv
// self-checking bench of the voltage-code register bank
// assumes the controller model in ivr_host_bfm and a pulled-up data wire
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin \
      cmp_count++; \
      if ((g) !== (e)) \
      begin \
         miscompares++; \
         $display("ERROR %s expected %h seen %h", nm, e, g); \
      end \
   end
module ivr_regs_tb;
   import ivr_pkg::*;

   localparam int         WD_CYC = 80000;
   localparam logic [6:0] ADR    = IVR_ADDR_DEF;

   logic       clk_sys;
   logic       rst_b;
   logic       scl;
   logic       host_sda;
   logic       sda_wire;
   logic       dut_sda;
   logic       dut_oe;
   logic       pwr_ok;
   logic       lockout;
   logic       enable;
   logic       int_mode;
   logic [6:0] vsel;
   logic       prot_sup;
   logic       light_load;
   logic       latch_off;
   logic [7:0] exp_v;
   logic [7:0] exp_c;
   int         miscompares = 0;
   int         cmp_count   = 0;
   int         seed        = 95457;

   // wired-and of both drivers with a pull-up
   assign sda_wire = host_sda & (dut_oe ? dut_sda : 1'b1);

   // 25 ns system clock
   initial clk_sys = 1'b0;
   always #12.5 clk_sys = ~clk_sys;

   ivr_regs #(.TGT_ADDR(ADR)) i_dut
   (
      .clk_sys_i              (clk_sys),
      .rst_b_i                (rst_b),
      .scl_i                  (scl),
      .sda_i                  (sda_wire),
      .sda_o                  (dut_sda),
      .sda_oe_o               (dut_oe),
      .supply_present_i       (pwr_ok),
      .supply_lockout_i       (lockout),
      .enable_i               (enable),
      .internal_mode_o        (int_mode),
      .voltage_select_value_o (vsel),
      .prot_suppress_o        (prot_sup),
      .light_load_select_o    (light_load),
      .latch_off_o            (latch_off)
   );

   ivr_host_bfm #(.Q(8)) i_host
   (
      .clk_sys_i (clk_sys),
      .sda_i     (sda_wire),
      .scl_o     (scl),
      .sda_o     (host_sda)
   );

   // expected register images
   function automatic logic [7:0] vimg(input logic [6:0] c);
      return {~^c, c};
   endfunction

   function automatic logic [7:0] cimg(input logic [7:0] f);
      return f & 8'h99;
   endfunction

   task automatic chk_out();
      `CHK("code", exp_v[6:0], vsel)
      `CHK("internal", exp_c[7], int_mode)
      `CHK("light_load", exp_c[3], light_load)
      `CHK("latch_off", exp_c[0], latch_off)
   endtask

   task automatic chk_rd(input logic [7:0] p, input logic [7:0] e);
      logic [7:0] d;
      logic       k;
      i_host.rd(ADR, p, d, k);
      `CHK("read ack", 1'b1, k)
      `CHK("read data", e, d)
   endtask

   task automatic results();
      $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // hang guard, well above the expected run length
   initial
   begin
      repeat (WD_CYC) @(posedge clk_sys);
      miscompares++;
      $display("ERROR watchdog expected done seen timeout");
      results();
   end

   // main sequence
   initial
   begin
      logic [2:0] a3;
      logic [6:0] c;
      logic [7:0] cf;
      logic [15:0] w;
      rst_b = 1'b0;
      pwr_ok = 1'b1;
      lockout = 1'b0;
      enable = 1'b1;
      exp_v = vimg(7'b0110010);
      exp_c = 8'h09;
      repeat (4) @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk_out();
      `CHK("suppress", 1'b0, prot_sup)
      chk_rd(8'h00, exp_v);
      chk_rd(8'h01, exp_c);
      $display("test defaults done");
      // extreme codes first, then random ones
      for (int i = 0; i < 6; i++)
      begin
         c = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'($random(seed));
         i_host.wr_code(ADR, c, a3);
         `CHK("write acks", 3'b111, a3)
         exp_v = vimg(c);
         chk_out();
         chk_rd(8'h00, exp_v);
      end
      $display("test code writes done");
      // wrong guard bit: refused, then resent correctly
      c = exp_v[6:0] ^ 7'h15;
      i_host.wr(ADR, 8'h00, {^c, c}, a3);
      `CHK("bad guard acks", 3'b110, a3)
      chk_out();
      chk_rd(8'h00, exp_v);
      i_host.wr_code(ADR, c, a3);
      exp_v = vimg(c);
      chk_out();
      // controller ack after a read byte: same register sent again
      i_host.rd2(ADR, w);
      `CHK("read again", {exp_v, exp_v}, w)
      $display("test guard done");
      // all ones then zero: internal mode set and dropped again
      for (int i = 0; i < 4; i++)
      begin
         cf = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
         i_host.wr(ADR, 8'h01, cf, a3);
         `CHK("cfg acks", 3'b111, a3)
         exp_c = cimg(cf);
         `CHK("internal", cf[7], int_mode)
         chk_out();
         chk_rd(8'h01, exp_c);
      end
      $display("test config done");
      // protection suppressed only with mask set, inside change window
      for (int m = 0; m < 2; m++)
      begin
         cf = (m == 1) ? 8'h10 : 8'h00;
         i_host.wr(ADR, 8'h01, cf, a3);
         exp_c = cimg(cf);
         c = exp_v[6:0] ^ 7'h01;
         i_host.wr_code(ADR, c, a3);
         exp_v = vimg(c);
         `CHK("suppress", m[0], prot_sup)
         repeat (700) @(negedge clk_sys);
         `CHK("suppress end", 1'b0, prot_sup)
      end
      $display("test mask done");
      // foreign address and unmapped offset change nothing
      i_host.wr(ADR ^ 7'h01, 8'h00, vimg(~exp_v[6:0]), a3);
      `CHK("foreign acks", 3'b000, a3)
      chk_out();
      i_host.wr(ADR, 8'h02, 8'hff, a3);
      chk_out();
      chk_rd(8'h02, 8'h00);
      chk_rd(8'h01, exp_c);
      $display("test unmapped done");
      // one-cycle spikes inside every bit of a write
      c = ~exp_v[6:0];
      i_host.spike_en = 1'b1;
      i_host.wr(ADR, 8'h00, vimg(c), a3);
      i_host.spike_en = 1'b0;
      `CHK("spike acks", 3'b111, a3)
      exp_v = vimg(c);
      chk_out();
      $display("test spikes done");
      // each default condition, last an async reset in mid-run
      for (int k = 0; k < 4; k++)
      begin
         i_host.wr(ADR, 8'h01, 8'h99, a3);
         i_host.wr_code(ADR, 7'h55, a3);
         pwr_ok = (k != 0);
         lockout = (k == 1);
         enable = (k != 2);
         rst_b = (k != 3);
         repeat (2) @(negedge clk_sys);
         pwr_ok = 1'b1;
         lockout = 1'b0;
         enable = 1'b1;
         rst_b = 1'b1;
         repeat (3) @(negedge clk_sys);
         exp_v = vimg(7'b0110010);
         exp_c = 8'h09;
         chk_out();
         chk_rd(8'h00, exp_v);
      end
      $display("test soft defaults done");
      results();
   end
endmodule
